// ===== cdtb_pkg.sv
// Purpose: shared constants and carriers for the debug/trace block
// Assumes: 32-bit breakpoint registers, 4-bit trace buses
// Notes: register indices serve both the core port and the serial channel
package cdtb_pkg;
    localparam int CDTB_W = 32;
    localparam int CDTB_NBP = 9;
    // register indices
    localparam logic [3:0] CDTB_ADDR = 4'h0;
    localparam logic [3:0] CDTB_ADDR_MASK = 4'h1;
    localparam logic [3:0] CDTB_DATA = 4'h2;
    localparam logic [3:0] CDTB_DATA_MASK = 4'h3;
    localparam logic [3:0] CDTB_PC0 = 4'h4;
    localparam logic [3:0] CDTB_PC_MASK = 4'h8;
    localparam logic [3:0] CDTB_CTRL = 4'h9;
    localparam logic [3:0] CDTB_STATUS = 4'hA;
    localparam logic [3:0] CDTB_RESUME = 4'hF;
    // control field positions
    localparam int CDTB_C_EN = 0;
    localparam int CDTB_C_TWO = 1;
    localparam int CDTB_C_IRQ = 2;
    localparam int CDTB_C_USE_A = 3;
    localparam int CDTB_C_USE_D = 4;
    localparam int CDTB_C_USE_PC = 5;
    localparam int CDTB_C_THR = 8;
    localparam logic [31:0] CDTB_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CDTB_REG_RST = 32'h0000_0000;
    localparam logic [3:0] CDTB_HALTED = 4'hF;
    localparam logic [3:0] CDTB_STATUS_BUS_RST = 4'h0;
    // serial frame: 8-bit command then 32-bit data
    localparam logic [5:0] CDTB_FRAME_LAST = 6'd39;
    localparam int CDTB_CMD_RD = 39;
    localparam logic [2:0] CDTB_NIB_LAST = 3'd7;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] pc;
    } cdtb_obs_s;

    typedef struct packed {
        logic [31:0] value;
    } cdtb_trace_s;

    typedef enum logic {CDTB_IDLE, CDTB_SHIFT} cdtb_ser_e;
endpackage : cdtb_pkg

// ===== cdtb_buf2.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous reset
// Notes: in_ready comes from a flop loaded from next_count, so it tracks count with no lag
`timescale 1ns/10ps
`default_nettype none
module cdtb_buf2 #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import cdtb_pkg::*;
    logic [W-1:0] mem [0:1];
    logic wptr;
    logic rptr;
    logic [1:0] count;
    logic [1:0] next_count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign next_count = count + {1'b0, push} - {1'b0, pop};
    assign out_valid = (count != 2'd0);
    assign out_data = mem[rptr];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wptr <= 1'b0;
            rptr <= 1'b0;
            count <= 2'd0;
            in_ready <= 1'b1;
        end else begin
            count <= next_count;
            in_ready <= (next_count != 2'd2);
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
endmodule : cdtb_buf2
`default_nettype wire

// ===== cdtb_top.sv
// Purpose: core debug module with breakpoints, triggers and trace output
// Assumes: core observation and trace words come from core_clk logic
// Notes: the serial clock is sampled, so it must be well below core_clk/4
//
// How it works
// R1 - nine 32-bit breakpoint registers: address, data, four PCs, three masks
// R2 - registers reachable by serial channel and by supervisor-mode software
// R3 - triggers combine address, data, PC matches; one or two levels
// R4 - a fired trigger halts the core or raises a debug interrupt
// R5 - critical interrupts still pass while a debug interrupt is handled
// R6 - 4-bit status and trace data buses with a trace clock
// R7 - trace buses carry status plus captured operands and branch targets
// R8 - halt indicator is the AND of the four status bits
// R9 - serial channel and halt indicator always; full trace only optionally
// R10 - mask bit set to one excludes that bit from its comparison
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cdtb_top #(
    parameter bit FULL_TRACE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    // supervisor-mode register port
    input wire logic sup_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // core observation
    input wire cdtb_pkg::cdtb_obs_s core_obs,
    input wire logic [3:0] core_status,
    input wire logic [2:0] irq_level,
    input wire logic dbg_irq_done,
    output logic halt_req,
    output logic dbg_irq_req,
    output logic [2:0] crit_irq_pass,
    // trace words from the core
    input wire logic trace_valid,
    input wire cdtb_pkg::cdtb_trace_s trace_word,
    output logic trace_ready,
    // debug serial channel
    input wire logic dbg_serial_in,
    input wire logic dbg_serial_clock,
    output logic dbg_serial_out,
    // trace pins
    output logic [3:0] proc_status_bus,
    output logic [3:0] trace_data_bus,
    output logic trace_clock_out,
    output logic halt_indicator
);
    import cdtb_pkg::*;

    // masked compare: equal on every bit the mask leaves at zero
    function automatic logic bp_match(input logic [31:0] obs,
                                      input logic [31:0] ref_v,
                                      input logic [31:0] mask);
        bp_match = (((obs ^ ref_v) & ~mask) == 32'h0000_0000); // see R10
    endfunction : bp_match

    logic [31:0] bp [0:CDTB_NBP-1];
    logic [31:0] ctrl;
    logic halted;
    logic dbg_active;
    logic armed;

    // serial link synchronisers and shifters
    logic [1:0] sclk_sync;
    logic [1:0] sin_sync;
    logic sclk_prev;
    logic [39:0] ser_in;
    logic [5:0] ser_cnt;
    logic [31:0] ser_out;

    wire sclk_rise = sclk_sync[1] && !sclk_prev;
    wire sclk_fall = !sclk_sync[1] && sclk_prev;
    wire [39:0] frame = {ser_in[38:0], sin_sync[1]};
    wire frame_done = sclk_rise && (ser_cnt == CDTB_FRAME_LAST);
    wire ser_is_rd = frame[CDTB_CMD_RD];
    wire [3:0] ser_idx = frame[35:32];
    wire ser_wr = frame_done && !ser_is_rd;
    wire ser_resume = ser_wr && (ser_idx == CDTB_RESUME);
    wire cpu_wr = reg_wr && sup_mode; // see R2

    // shared register read mux
    function automatic logic [31:0] reg_view(input logic [3:0] idx,
                                             input logic [31:0] c,
                                             input logic [2:0] st,
                                             input logic [31:0] v);
        if (idx < CDTB_CTRL) begin
            reg_view = v;
        end else if (idx == CDTB_CTRL) begin
            reg_view = c;
        end else if (idx == CDTB_STATUS) begin
            reg_view = {29'h0, st};
        end else begin
            reg_view = 32'h0000_0000;
        end
    endfunction : reg_view

    wire [2:0] status_bits = {armed, dbg_active, halted};
    wire [31:0] cpu_view = reg_view(reg_addr, ctrl, status_bits,
                                    bp[reg_addr < CDTB_CTRL ? reg_addr : 4'h0]);
    wire [31:0] ser_view = reg_view(ser_idx, ctrl, status_bits,
                                    bp[ser_idx < CDTB_CTRL ? ser_idx : 4'h0]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclk_sync <= 2'b00;
            sin_sync <= 2'b00;
            sclk_prev <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], dbg_serial_clock};
            sin_sync <= {sin_sync[0], dbg_serial_in};
            sclk_prev <= sclk_sync[1];
        end
    end

    // frame in on rising edges, answer out on falling edges
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ser_in <= 40'h00_0000_0000;
            ser_cnt <= 6'd0;
            ser_out <= 32'h0000_0000;
            dbg_serial_out <= 1'b0;
        end else begin
            if (sclk_rise) begin
                ser_in <= frame;
                ser_cnt <= frame_done ? 6'd0 : ser_cnt + 6'd1;
            end
            if (frame_done && ser_is_rd) begin
                ser_out <= ser_view; // see R2
            end else if (sclk_fall) begin
                dbg_serial_out <= ser_out[31];
                ser_out <= {ser_out[30:0], 1'b0};
            end
        end
    end

    // breakpoint and control registers; core port wins over serial
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < CDTB_NBP; i++) begin
                bp[i] <= CDTB_REG_RST; // see R1
            end
            ctrl <= CDTB_CTRL_RST;
        end else begin
            if (ser_wr && ser_idx < CDTB_CTRL) begin
                bp[ser_idx] <= frame[31:0]; // see R2
            end
            if (ser_wr && ser_idx == CDTB_CTRL) begin
                ctrl <= frame[31:0];
            end
            if (cpu_wr && reg_addr < CDTB_CTRL) begin
                bp[reg_addr] <= reg_wdata; // see R2
            end
            if (cpu_wr && reg_addr == CDTB_CTRL) begin
                ctrl <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= (reg_rd && sup_mode) ? cpu_view : 32'h0000_0000;
        end
    end

    // match and trigger formation
    wire m_addr = bp_match(core_obs.addr, bp[CDTB_ADDR], bp[CDTB_ADDR_MASK]);
    wire m_data = bp_match(core_obs.data, bp[CDTB_DATA], bp[CDTB_DATA_MASK]);
    logic m_pc;
    always_comb begin
        m_pc = 1'b0;
        for (int i = 0; i < 4; i++) begin
            m_pc = m_pc | bp_match(core_obs.pc, bp[CDTB_PC0 + 4'(i)],
                                   bp[CDTB_PC_MASK]);
        end
    end

    // unused terms count as matched; a level with no term never fires
    wire use_a = ctrl[CDTB_C_USE_A];
    wire use_d = ctrl[CDTB_C_USE_D];
    wire use_p = ctrl[CDTB_C_USE_PC];
    wire ad_cond = (use_a || use_d) && (!use_a || m_addr)
                   && (!use_d || m_data); // see R3
    wire one_cond = (use_a || use_d || use_p) && (!use_a || m_addr)
                    && (!use_d || m_data) && (!use_p || m_pc); // see R3
    wire two_lvl = ctrl[CDTB_C_TWO];
    wire trig_on = ctrl[CDTB_C_EN] && core_obs.valid;
    // two levels: address/data arms, then a PC match fires
    wire fire = trig_on && (two_lvl ? (armed && use_p && m_pc)
                                    : one_cond); // see R3
    wire arm_set = trig_on && two_lvl && !armed && ad_cond;
    wire fire_halt = fire && !ctrl[CDTB_C_IRQ];
    wire fire_irq = fire && ctrl[CDTB_C_IRQ];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            armed <= 1'b0;
            halted <= 1'b0;
            dbg_active <= 1'b0;
        end else begin
            armed <= arm_set || (armed && !fire && two_lvl); // see R3
            // a new event beats a clear in the same cycle
            halted <= fire_halt || (halted && !ser_resume); // see R4
            dbg_active <= fire_irq || (dbg_active && !dbg_irq_done);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            halt_req <= 1'b0;
            dbg_irq_req <= 1'b0;
            crit_irq_pass <= 3'd0;
        end else begin
            halt_req <= fire_halt || (halted && !ser_resume); // see R4
            dbg_irq_req <= fire_irq; // see R4
            // only levels at or above the threshold reach the core meanwhile
            crit_irq_pass <= (!dbg_active ||
                irq_level >= ctrl[CDTB_C_THR +: 3]) ? irq_level
                                                    : 3'd0; // see R5
        end
    end

    // trace path: buffered words go out a nibble per cycle
    cdtb_trace_s buf_data;
    logic buf_valid;
    logic buf_ready;
    cdtb_ser_e tstate;
    logic [31:0] tshift;
    logic [2:0] nib;

    cdtb_buf2 #(.W($bits(cdtb_trace_s))) u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(trace_valid && FULL_TRACE),
        .in_ready(trace_ready),
        .in_data(trace_word),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    assign buf_ready = (tstate == CDTB_IDLE);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tstate <= CDTB_IDLE;
            tshift <= 32'h0000_0000;
            nib <= 3'd0;
        end else begin
            case (tstate)
                CDTB_IDLE: begin
                    if (buf_valid) begin
                        tshift <= buf_data.value; // see R7
                        nib <= 3'd0;
                        tstate <= CDTB_SHIFT;
                    end
                end
                CDTB_SHIFT: begin
                    tshift <= {4'h0, tshift[31:4]};
                    nib <= nib + 3'd1;
                    if (nib == CDTB_NIB_LAST) begin
                        tstate <= CDTB_IDLE;
                    end
                end
                default: tstate <= CDTB_IDLE;
            endcase
        end
    end

    // status shows all ones while halted, else the core's own code
    wire [3:0] next_status = halted ? CDTB_HALTED : core_status;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            proc_status_bus <= CDTB_STATUS_BUS_RST;
            trace_data_bus <= 4'h0;
            trace_clock_out <= 1'b0;
            halt_indicator <= 1'b0;
        end else begin
            // halt indicator survives without the full trace bonding
            halt_indicator <= &next_status; // see R8
            proc_status_bus <= FULL_TRACE ? next_status : 4'h0; // see R6 R9
            trace_data_bus <= (FULL_TRACE && tstate == CDTB_SHIFT)
                              ? tshift[3:0] : 4'h0; // see R6 R7
            // flop output: one edge of the pin per core cycle
            trace_clock_out <= FULL_TRACE ? ~trace_clock_out : 1'b0; // see R6
        end
    end
endmodule : cdtb_top
`default_nettype wire

// ===== cdtb_props.sv
// Purpose: port-level assertions for the debug and trace block
// Assumes: one core_clk domain, synchronous active-high rst
// Notes: attached to every instance of the top module by bind
`timescale 1ns/10ps
`default_nettype none
module cdtb_props
    import cdtb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sup_mode,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0] irq_level,
    input wire logic halt_req,
    input wire logic dbg_irq_req,
    input wire logic [2:0] crit_irq_pass,
    input wire logic trace_valid,
    input wire logic trace_ready,
    input wire logic [3:0] proc_status_bus,
    input wire logic trace_clock_out,
    input wire logic halt_indicator
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_hind; halt_indicator == (&proc_status_bus); endproperty
    a_hind: assert property (p_hind)
        else $error("halt indicator disagrees with status bus");
    property p_tclk; !$past(rst) |-> $changed(trace_clock_out); endproperty
    a_tclk: assert property (p_tclk)
        else $error("trace clock missed a toggle");
    property p_hpst;
        $rose(halt_req) |-> ##[0:2] proc_status_bus == CDTB_HALTED;
    endproperty
    a_hpst: assert property (p_hpst)
        else $error("halted core without halted status code");
    // resume needs a full serial frame, so a halt lasts far longer
    property p_hhold; $rose(halt_req) |=> halt_req [*4]; endproperty
    a_hhold: assert property (p_hhold)
        else $error("halt dropped too early");
    property p_ipulse; dbg_irq_req |=> !dbg_irq_req; endproperty
    a_ipulse: assert property (p_ipulse)
        else $error("debug interrupt request longer than one cycle");
    property p_iact; dbg_irq_req |-> !$rose(halt_req); endproperty
    a_iact: assert property (p_iact)
        else $error("interrupt and halt raised together");
    property p_rdidle;
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdidle: assert property (p_rdidle)
        else $error("read data outside its cycle");
    property p_rdsup;
        reg_rd && !sup_mode |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdsup: assert property (p_rdsup)
        else $error("read answered outside supervisor mode");
    property p_crit;
        crit_irq_pass != 3'h0 |-> crit_irq_pass == $past(irq_level);
    endproperty
    a_crit: assert property (p_crit)
        else $error("passed interrupt level differs from pending level");
    c_halt: cover property ($rose(halt_req));
    c_irq: cover property (dbg_irq_req);
    c_full: cover property (trace_valid && !trace_ready);
    c_pass: cover property (crit_irq_pass != 3'h0);
endmodule : cdtb_props
bind cdtb_top cdtb_props u_props (
    .core_clk(core_clk), .rst(rst), .sup_mode(sup_mode), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_level(irq_level), .halt_req(halt_req),
    .dbg_irq_req(dbg_irq_req), .crit_irq_pass(crit_irq_pass),
    .trace_valid(trace_valid), .trace_ready(trace_ready),
    .proc_status_bus(proc_status_bus), .trace_clock_out(trace_clock_out),
    .halt_indicator(halt_indicator)
);
`default_nettype wire

// ===== cdtb_dbg_model.sv
// Purpose: external debugger model on the serial debug channel
// Assumes: serial clock idles low between frames, 320 ns period
// Notes: a read answer comes back during the frame that follows it
`timescale 1ns/10ps
`default_nettype none
module cdtb_dbg_model (
    output logic dbg_serial_clock,
    output logic dbg_serial_in,
    input wire logic dbg_serial_out
);
    initial begin
        dbg_serial_clock = 1'b0;
        dbg_serial_in = 1'b0;
    end
    // sample just before the fall: the answer only moves after a fall
    task automatic frame(input logic rd, input logic [3:0] idx,
                         input logic [31:0] d, output logic [31:0] rsp);
        logic [39:0] f;
        f = {rd, 3'b000, idx, d};
        for (int i = 39; i >= 0; i--) begin
            dbg_serial_in = f[i];
            #160 dbg_serial_clock = 1'b1;
            #150 if (i > 7) rsp[i-8] = dbg_serial_out;
            #10 dbg_serial_clock = 1'b0;
        end
        #640;
    endtask : frame
endmodule : cdtb_dbg_model
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the debug and trace block
// Assumes: 25 MHz core clock, debugger model on the serial channel
// Notes: random values from a fixed seed around hand-picked triggers
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cdtb_pkg::*;
    logic core_clk, rst, sup_mode, reg_wr, reg_rd, dbg_irq_done;
    logic trace_valid, trace_ready, halt_req, dbg_irq_req, halt_indicator;
    logic [3:0] reg_addr, core_status, proc_status_bus, trace_data_bus;
    logic [31:0] reg_wdata, reg_rdata, v[9], w[4], r, a, m;
    logic [2:0] irq_level, crit_irq_pass;
    logic dbg_serial_in, dbg_serial_clock, dbg_serial_out, trace_clock_out;
    cdtb_obs_s core_obs;
    cdtb_trace_s trace_word;
    integer seed = 32'h3820ff48;
    int error_cnt = 0, cmp_count = 0, n;
    cdtb_top dut (
        .core_clk(core_clk), .rst(rst), .sup_mode(sup_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_obs(core_obs),
        .core_status(core_status), .irq_level(irq_level),
        .dbg_irq_done(dbg_irq_done), .halt_req(halt_req),
        .dbg_irq_req(dbg_irq_req), .crit_irq_pass(crit_irq_pass),
        .trace_valid(trace_valid), .trace_word(trace_word),
        .trace_ready(trace_ready), .dbg_serial_in(dbg_serial_in),
        .dbg_serial_clock(dbg_serial_clock), .dbg_serial_out(dbg_serial_out),
        .proc_status_bus(proc_status_bus), .trace_data_bus(trace_data_bus),
        .trace_clock_out(trace_clock_out), .halt_indicator(halt_indicator)
    );
    cdtb_dbg_model u_dbg (
        .dbg_serial_clock(dbg_serial_clock),
        .dbg_serial_in(dbg_serial_in),
        .dbg_serial_out(dbg_serial_out)
    );
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("reg_rdata", reg_rdata, e);
    endtask : rd
    task automatic obs(input logic [31:0] ad, dt, pc);
        @(posedge core_clk);
        core_obs <= '{1'b1, ad, dt, pc};
        @(posedge core_clk);
        core_obs.valid <= 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : obs
    // valid stays up across words so no edge sees it dropped and raised
    task automatic push4(output int nr);
        nr = 0;
        @(posedge core_clk);
        trace_valid <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            trace_word <= '{w[k]};
            do begin
                @(posedge core_clk);
                nr += !trace_ready;
            end while (!trace_ready);
        end
        trace_valid <= 1'b0;
    endtask : push4
    task automatic take(output logic [31:0] q);
        int t = 0;
        while (trace_data_bus === 4'h0 && t < 40) begin
            @(negedge core_clk);
            t++;
        end
        for (int i = 0; i < 8; i++) begin
            q[4*i +: 4] = trace_data_bus;
            @(negedge core_clk);
        end
    endtask : take
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end
    initial begin
        {rst, sup_mode, reg_wr, reg_rd, dbg_irq_done, trace_valid} = 6'h30;
        {reg_addr, core_status, irq_level, reg_wdata} = '0;
        core_obs = '0;
        trace_word = '0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            v[i] = $random(seed);
            rd(i[3:0], 32'h0000_0000);
            wr(i[3:0], v[i]);
        end
        for (int i = 0; i < 9; i++) rd(i[3:0], v[i]);
        rd(4'hC, 32'h0000_0000);
        @(posedge core_clk);
        sup_mode <= 1'b0;
        wr(CDTB_ADDR, ~v[0]);
        rd(CDTB_ADDR, 32'h0000_0000);
        @(posedge core_clk);
        sup_mode <= 1'b1;
        rd(CDTB_ADDR, v[0]);
        r = $random(seed);
        u_dbg.frame(1'b0, CDTB_DATA, r, a);
        repeat (8) @(negedge core_clk);
        rd(CDTB_DATA, r);
        u_dbg.frame(1'b1, CDTB_PC0, '0, a);
        u_dbg.frame(1'b1, CDTB_STATUS, '0, a);
        chk("serial read", a, v[4]);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            core_status <= k[1] ? 4'($random(seed)) : 4'hF - 4'(k);
            repeat (2) @(negedge core_clk);
            chk("status", 32'(proc_status_bus), 32'(core_status));
            chk("all ones", 32'(halt_indicator), 32'(&core_status));
        end
        @(posedge core_clk);
        core_status <= 4'h1;
        a = $random(seed);
        m = $random(seed) & 32'h0FFF_FFF0;
        wr(CDTB_ADDR, a);
        wr(CDTB_ADDR_MASK, m);
        wr(CDTB_CTRL, 32'h0000_0009);
        obs(a ^ 32'h0000_0001, $random(seed), $random(seed));
        chk("unmasked miss", 32'(halt_req), 32'h0);
        obs(a ^ (m & $random(seed)), '0, '0);
        chk("masked hit", 32'(halt_req), 32'h1);
        chk("halt code", 32'(proc_status_bus), 32'hF);
        rd(CDTB_STATUS, 32'h0000_0001);
        u_dbg.frame(1'b0, CDTB_RESUME, '0, m);
        chk("serial status", m, 32'h0000_0000);
        repeat (8) @(negedge core_clk);
        chk("resume", 32'(halt_req), 32'h0);
        wr(CDTB_DATA_MASK, '0);
        wr(CDTB_CTRL, 32'h0000_0515);
        irq_level <= 3'd6;
        fork
            obs(a, r, a);
            repeat (8) begin
                @(negedge core_clk);
                n += (dbg_irq_req === 1'b1);
            end
        join
        chk("irq pulses", 32'(n), 32'h1);
        chk("irq no halt", 32'(halt_req), 32'h0);
        rd(CDTB_STATUS, 32'h0000_0002);
        chk("crit high", 32'(crit_irq_pass), 32'h6);
        @(posedge core_clk);
        irq_level <= 3'd3;
        repeat (3) @(negedge core_clk);
        chk("crit low", 32'(crit_irq_pass), 32'h0);
        @(posedge core_clk);
        dbg_irq_done <= 1'b1;
        @(posedge core_clk);
        dbg_irq_done <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk("after done", 32'(crit_irq_pass), 32'h3);
        wr(CDTB_ADDR_MASK, '0);
        wr(CDTB_PC_MASK, '0);
        wr(CDTB_CTRL, 32'h0000_002B);
        obs(~a, '0, v[5]);
        chk("pc before arm", 32'(halt_req), 32'h0);
        obs(a, '0, ~v[5]);
        rd(CDTB_STATUS, 32'h0000_0004);
        obs(~a, '0, v[5]);
        chk("second level", 32'(halt_req), 32'h1);
        u_dbg.frame(1'b0, CDTB_RESUME, '0, m);
        for (int k = 0; k < 4; k++) w[k] = $random(seed) | 32'h1;
        fork
            push4(n);
            for (int k = 0; k < 4; k++) begin
                take(r);
                chk("trace word", r, w[k]);
            end
        join
        chk("buffer refused", 32'(n > 0), 32'h1);
        finish_test();
    end
endmodule : tb
`default_nettype wire
